//--- hw/fssb_guard.sv
/*
  one sector guard byte with its lock decode. assumes the parent decides when
  a write, a write-lock clear or a full clear applies.
*/
`default_nettype none
module fssb_guard
  import fssb_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // updates
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       clr_write_lock,
  input  wire logic       clr_all,
  // state
  output logic [7:0]      guard_byte,
  output logic            erase_lock,
  output logic            sector_write_lock,
  output logic            code_read_lock
);
  logic [7:0] guard_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      guard_r <= GUARD_RESET; // RULE1
    end else if (clr_all) begin
      guard_r <= GUARD_RESET; // RULE3
    end else if (clr_write_lock) begin
      guard_r[WRITE_LOCK_BIT] <= 1'b0; // RULE4
    end else if (wr_en) begin
      guard_r <= guard_r | (wr_data & GUARD_MASK); // RULE2
    end
  end

  assign guard_byte        = guard_r;
  assign erase_lock        = guard_r[ERASE_LOCK_BIT];
  assign sector_write_lock = guard_r[WRITE_LOCK_BIT];
  assign code_read_lock    = guard_r[READ_LOCK_BIT];
endmodule : fssb_guard
`default_nettype wire

//--- hw/fssb_pkg.sv
/*
  package for the flash sector security and boot block: command codes, field positions,
  reset values, byte indices of the security bytes. assumes a host flash controller
  that presents one command at a time and performs the array write itself.
*/
// Behaviour
// RULE1: four per-sector guard bytes, each reads 0x00 when unprogrammed.
// RULE2: guard byte bit2 erase lock, bit1 write lock, bit0 code-read lock, rest zero.
// RULE3: erase lock set blocks firmware erase of sector and lock; programmer global erase clears.
// RULE4: any sector erase or global erase clears the sector write lock with contents.
// RULE5: write lock alone aborts program and page erase; sector/global erase still allowed.
// RULE6: erase lock set aborts every program or erase to sector except global erase.
// RULE7: code-read lock aborts that sector's CRC, flags violation, marks CRC invalid.
// RULE8: global CRC aborts and flags violation if any sector has code-read lock.
// RULE9: code-read lock alone never flags program or erase commands.
// RULE10: boot vector byte holds five-bit vector in bits 4..0, reset 0x00, rest zero.
// RULE11: boot address is boot vector in upper bits with low byte 0x00.
// RULE12: boot state bit0 set forces every reset to start at boot vector address.
// RULE13: boot state bits 7..1 reserved zero, byte resets to 0x00.
// RULE14: aborted command completes without flash write; violation flag held until read or cleared.
`default_nettype none
package fssb_pkg;
  localparam int unsigned      NUM_SECTORS     = 4;
  localparam logic [7:0]       GUARD_RESET     = 8'h00;
  localparam logic [7:0]       BOOT_PAGE_VECTOR_RESET   = 8'h00;
  localparam logic [7:0]       BOOTSTATE_RESET = 8'h00;
  localparam int unsigned      ERASE_LOCK_BIT  = 2;
  localparam int unsigned      WRITE_LOCK_BIT  = 1;
  localparam int unsigned      READ_LOCK_BIT   = 0;
  localparam logic [7:0]       GUARD_MASK      = 8'h07;
  localparam logic [7:0]       BOOT_PAGE_VECTOR_MASK    = 8'h1f;
  localparam logic [7:0]       BOOTSTATE_MASK  = 8'h01;
  localparam logic [7:0]       BOOT_LOW_BYTE   = 8'h00;
  // configuration byte indices on the config port
  localparam logic [2:0]       CFG_GUARD0      = 3'h0;
  localparam logic [2:0]       CFG_BOOT_PAGE_VECTOR     = 3'h4;
  localparam logic [2:0]       CFG_BOOTSTATE   = 3'h5;
  localparam logic [2:0]       CFG_STATUS      = 3'h6;
  localparam logic [7:0]       STATUS_VIOL_BIT = 8'h01;

  typedef enum logic [2:0] {
    FSSB_CMD_PROGRAM    = 3'h0,
    FSSB_CMD_PAGE_ERASE = 3'h1,
    FSSB_CMD_SECT_ERASE = 3'h2,
    FSSB_CMD_GLOB_ERASE = 3'h3,
    FSSB_CMD_SECT_CRC   = 3'h4,
    FSSB_CMD_GLOB_CRC   = 3'h5,
    FSSB_CMD_CFG_WRITE  = 3'h6
  } fssb_cmd_type;
endpackage : fssb_pkg
`default_nettype wire

//--- hw/fssb_top.sv
/*
  flash sector security check and boot address selection. a command source
  (firmware or external programmer) presents one command with cmd_valid; the
  verdict answers one cycle later. assumes the host flash controller performs
  allowed array writes when go_pulse is seen and programs config bytes through
  this block's config write command.
*/
`default_nettype none
module fssb_top
  import fssb_pkg::*;
#(
  parameter int unsigned SECT_W = 2
)
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // command request
  input  wire logic              cmd_valid,
  input  wire logic [2:0]        cmd_code,
  input  wire logic [SECT_W-1:0] cmd_sector,
  input  wire logic              cmd_from_programmer,
  input  wire logic [2:0]        cfg_index,
  input  wire logic [7:0]        cfg_data,
  // verdict
  output logic                   done_pulse,
  output logic                   go_pulse,
  output logic                   abort_pulse,
  output logic                   crc_valid,
  output logic                   violation_flag,
  // status access
  input  wire logic              stat_read,
  input  wire logic              viol_clear,
  output logic [7:0]             read_data,
  // boot
  output logic                   force_boot_vector,
  output logic [15:0]            reset_address
);
  logic [NUM_SECTORS-1:0] erase_lock;
  logic [NUM_SECTORS-1:0] sector_write_lock;
  logic [NUM_SECTORS-1:0] code_read_lock;
  logic [7:0]             guard_byte [NUM_SECTORS];
  logic [NUM_SECTORS-1:0] guard_wr;
  logic [NUM_SECTORS-1:0] guard_clr_wl;
  logic [NUM_SECTORS-1:0] guard_clr_all;
  logic [7:0]             boot_page_vector_r;
  logic [7:0]             boot_state_byte_r;
  logic                   violation_r;
  logic                   done_r;
  logic                   go_r;
  logic                   abort_r;
  logic                   crc_valid_r;
  logic [7:0]             read_data_r;
  logic                   allow;
  logic                   is_crc;
  logic                   sel_erase;
  logic                   sel_write;
  logic                   sel_read;
  fssb_cmd_type           cmd;

  assign cmd       = fssb_cmd_type'(cmd_code);
  assign sel_erase = erase_lock[cmd_sector];
  assign sel_write = sector_write_lock[cmd_sector];
  assign sel_read  = code_read_lock[cmd_sector];
  assign is_crc    = (cmd == FSSB_CMD_SECT_CRC) || (cmd == FSSB_CMD_GLOB_CRC);

  // security verdict; code-read lock never enters write or erase decisions
  always_comb begin
    case (cmd)
      FSSB_CMD_PROGRAM,
      FSSB_CMD_PAGE_ERASE: allow = !sel_erase && !sel_write; // RULE5 RULE6 RULE9
      FSSB_CMD_SECT_ERASE: allow = !sel_erase;               // RULE5 RULE6 RULE3
      FSSB_CMD_GLOB_ERASE: allow = cmd_from_programmer || (erase_lock == '0); // RULE3 RULE6
      FSSB_CMD_SECT_CRC:   allow = !sel_read;                // RULE7
      FSSB_CMD_GLOB_CRC:   allow = (code_read_lock == '0);   // RULE8
      FSSB_CMD_CFG_WRITE:  allow = 1'b1;
      default:             allow = 1'b0;
    endcase
  end

  // guard byte updates only on allowed commands
  always_comb begin
    for (int i = 0; i < NUM_SECTORS; i++) begin
      guard_wr[i]      = cmd_valid && (cmd == FSSB_CMD_CFG_WRITE) &&
                         (cfg_index == CFG_GUARD0 + 3'(i));
      guard_clr_wl[i]  = cmd_valid && allow && (cmd == FSSB_CMD_SECT_ERASE) &&
                         (cmd_sector == SECT_W'(i)); // RULE4
      guard_clr_all[i] = cmd_valid && allow && (cmd == FSSB_CMD_GLOB_ERASE); // RULE3 RULE4
    end
  end

  for (genvar g = 0; g < NUM_SECTORS; g++) begin : g_guard
    fssb_guard u_guard (
      .clk               (clk),
      .srst              (srst),
      .wr_en             (guard_wr[g]),
      .wr_data           (cfg_data),
      .clr_write_lock    (guard_clr_wl[g]),
      .clr_all           (guard_clr_all[g]),
      .guard_byte        (guard_byte[g]),
      .erase_lock        (erase_lock[g]),
      .sector_write_lock (sector_write_lock[g]),
      .code_read_lock    (code_read_lock[g])
    );
  end

  // boot configuration bytes; reserved bits forced to zero
  always_ff @(posedge clk) begin
    if (srst) begin
      boot_page_vector_r <= BOOT_PAGE_VECTOR_RESET;   // RULE10
      boot_state_byte_r  <= BOOTSTATE_RESET; // RULE13
    end else if (cmd_valid && (cmd == FSSB_CMD_CFG_WRITE)) begin
      if (cfg_index == CFG_BOOT_PAGE_VECTOR) begin
        boot_page_vector_r <= cfg_data & BOOT_PAGE_VECTOR_MASK; // RULE10
      end
      if (cfg_index == CFG_BOOTSTATE) begin
        boot_state_byte_r <= cfg_data & BOOTSTATE_MASK; // RULE13
      end
    end
  end

  // command verdict, one cycle after the request
  always_ff @(posedge clk) begin
    if (srst) begin
      done_r      <= 1'b0;
      go_r        <= 1'b0;
      abort_r     <= 1'b0;
      crc_valid_r <= 1'b0;
    end else begin
      done_r  <= cmd_valid;
      go_r    <= cmd_valid && allow;  // RULE14
      abort_r <= cmd_valid && !allow; // RULE14
      if (cmd_valid && is_crc) begin
        crc_valid_r <= allow; // RULE7
      end
    end
  end

  // sticky violation flag; a new violation wins over a clear or read
  always_ff @(posedge clk) begin
    if (srst) begin
      violation_r <= 1'b0;
    end else if (cmd_valid && !allow) begin
      violation_r <= 1'b1; // RULE5 RULE6 RULE7 RULE8
    end else if (viol_clear || stat_read) begin
      violation_r <= 1'b0; // RULE14
    end
  end

  // config read-back
  always_ff @(posedge clk) begin
    if (srst) begin
      read_data_r <= 8'h00;
    end else begin
      case (cfg_index)
        3'h0, 3'h1, 3'h2, 3'h3: read_data_r <= guard_byte[cfg_index[1:0]];
        CFG_BOOT_PAGE_VECTOR:            read_data_r <= boot_page_vector_r;
        CFG_BOOTSTATE:          read_data_r <= boot_state_byte_r;
        CFG_STATUS:             read_data_r <= violation_r ? STATUS_VIOL_BIT : 8'h00;
        default:                read_data_r <= 8'h00;
      endcase
    end
  end

  assign done_pulse        = done_r;
  assign go_pulse          = go_r;
  assign abort_pulse       = abort_r;
  assign crc_valid         = crc_valid_r;
  assign violation_flag    = violation_r;
  assign read_data         = read_data_r;
  assign force_boot_vector = boot_state_byte_r[0]; // RULE12
  assign reset_address     = {boot_page_vector_r, BOOT_LOW_BYTE}; // RULE11
endmodule : fssb_top
`default_nettype wire

//--- verification/fssb_bench.sv
/* bench for fssb_top: model compare; assumes fssb_source drives commands */
`default_nettype none
module fssb_bench;
  import fssb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1;
  logic v, p, sr, vc, dn, go, ab, cv, vf_o, fb;
  logic [2:0] c, i;
  logic [1:0] s;
  logic [7:0] d, rd;
  logic [15:0] ra;
  logic [7:0] g[4];
  logic [7:0] bv, bs;
  int vf, bad_count, n_tests;
  always #4 clk = ~clk;
  fssb_source i_src (.clk(clk), .cmd_valid(v), .cmd_code(c), .cmd_sector(s), .cmd_from_programmer(p),
    .cfg_index(i), .cfg_data(d), .stat_read(sr), .viol_clear(vc));
  fssb_top #(.SECT_W(2)) i_dut (.clk(clk), .srst(srst), .cmd_valid(v), .cmd_code(c), .cmd_sector(s),
    .cmd_from_programmer(p), .cfg_index(i), .cfg_data(d), .done_pulse(dn), .go_pulse(go),
    .abort_pulse(ab), .crc_valid(cv), .violation_flag(vf_o), .stat_read(sr), .viol_clear(vc),
    .read_data(rd), .force_boot_vector(fb), .reset_address(ra));
  task automatic chk(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("tests=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic run(input int cc, ss, pp, ii, dd, rr, xx);
    int a, ae, ar;
    {a, ae, ar} = '0;
    for (int k = 0; k < 4; k++) {ae, ar} = {ae | g[k][2], ar | g[k][0]};
    case (cc)
      0, 1: a = g[ss][2] | g[ss][1];
      2: a = g[ss][2];
      3: a = ae & !pp;
      4: a = g[ss][0];
      5: a = ar;
      default: a = 0;
    endcase
    chk(ra, {bv, 8'h00});
    chk(fb, bs[0]);
    i_src.send(cc, ss, pp, ii, dd, rr, xx);
    vf = a ? 1 : (rr | xx) ? 0 : vf;
    chk(dn, 1);
    if (cc < 6) chk({go, ab}, {a == 0, a != 0});
    if (cc == 4 || cc == 5) chk(cv, !a);
    chk(vf_o, vf);
    if (!a && cc == 2) g[ss][1] = 0;
    if (!a && cc == 3) g = '{default: 8'h00};
    if (cc == 6 && ii < 4) g[ii] |= dd & 8'h07;
    if (cc == 6 && ii == 4) bv = dd & 8'h1f;
    if (cc == 6 && ii == 5) bs = dd & 8'h01;
  endtask : run
  task automatic read_all();
    for (int k = 0; k < 7; k++) begin
      i_src.look(k);
      chk(rd, k < 4 ? g[k] : k == 4 ? bv : k == 5 ? bs : vf);
    end
  endtask : read_all
  initial begin
    // longest run is about 1250 cycles
    #100000;
    bad_count++;
    stop_test();
  end
  initial begin
    {bv, bs, vf, bad_count, n_tests} = '0;
    g = '{default: 8'h00};
    repeat (16) @(negedge clk);
    srst = 0;
    read_all();
    void'($urandom(3));
    repeat (600) run($urandom % 7, $urandom % 4, $urandom % 4 == 0, $urandom % 6, $urandom,
                     $urandom % 5 == 0, $urandom % 6 == 0);
    read_all();
    stop_test();
  end
endmodule : fssb_bench
`default_nettype wire

//--- verification/fssb_checker.sv
/* fssb_top port checker; bound to every fssb_top instance */
`default_nettype none
module fssb_checker
  import fssb_pkg::*;
(
  // command side
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        cmd_valid,
  input wire logic [2:0]  cmd_code,
  input wire logic        cmd_from_programmer,
  input wire logic        stat_read,
  input wire logic        viol_clear,
  // verdict side
  input wire logic        done_pulse,
  input wire logic        go_pulse,
  input wire logic        abort_pulse,
  input wire logic        crc_valid,
  input wire logic        violation_flag,
  input wire logic [15:0] reset_address
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_take; cmd_valid ##1 done_pulse; endsequence
  property p_take; cmd_valid |-> s_take; endproperty
  property p_idle; !cmd_valid |=> !done_pulse; endproperty
  property p_one; done_pulse == (go_pulse ^ abort_pulse) && !(go_pulse && abort_pulse); endproperty
  property p_fset; abort_pulse |-> violation_flag; endproperty
  property p_fsrc; $rose(violation_flag) |-> abort_pulse; endproperty
  property p_fclr; violation_flag && (stat_read || viol_clear) && !cmd_valid |=> !violation_flag; endproperty
  property p_fhold; violation_flag && !stat_read && !viol_clear |=> violation_flag; endproperty
  property p_crc; cmd_valid && cmd_code inside {FSSB_CMD_SECT_CRC, FSSB_CMD_GLOB_CRC} |=> crc_valid == go_pulse;
  endproperty
  property p_ckeep; !(cmd_valid && cmd_code[2:1] == 2'h2) |=> $stable(crc_valid); endproperty
  property p_glob; cmd_valid && cmd_code == FSSB_CMD_GLOB_ERASE && cmd_from_programmer |=> go_pulse; endproperty
  property p_boot; reset_address[7:0] == BOOT_LOW_BYTE && reset_address[15:13] == 3'h0; endproperty
  a_take: assert property (p_take) else $error("no done after command");
  a_idle: assert property (p_idle) else $error("done without command");
  a_one: assert property (p_one) else $error("verdict not one of go or abort");
  a_fset: assert property (p_fset) else $error("abort without flag");
  a_fsrc: assert property (p_fsrc) else $error("flag rose without abort");
  a_fclr: assert property (p_fclr) else $error("flag not cleared");
  a_fhold: assert property (p_fhold) else $error("flag dropped");
  a_crc: assert property (p_crc) else $error("crc result wrong");
  a_ckeep: assert property (p_ckeep) else $error("crc result moved");
  a_glob: assert property (p_glob) else $error("programmer erase refused");
  a_boot: assert property (p_boot) else $error("boot address form");
endmodule : fssb_checker
bind fssb_top fssb_checker i_chk (.clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .cmd_from_programmer(cmd_from_programmer), .stat_read(stat_read), .viol_clear(viol_clear),
  .done_pulse(done_pulse), .go_pulse(go_pulse), .abort_pulse(abort_pulse), .crc_valid(crc_valid),
  .violation_flag(violation_flag), .reset_address(reset_address));
`default_nettype wire

//--- verification/fssb_source.sv
/* command source model; assumes its clk is the block's clock */
`default_nettype none
module fssb_source (
  // clock
  input  wire logic clk,
  // requests
  output var logic       cmd_valid,
  output var logic [2:0] cmd_code,
  output var logic [1:0] cmd_sector,
  output var logic       cmd_from_programmer,
  output var logic [2:0] cfg_index,
  output var logic [7:0] cfg_data,
  output var logic       stat_read,
  output var logic       viol_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cmd_valid, cmd_code, cmd_sector, cmd_from_programmer, cfg_index, cfg_data, stat_read, viol_clear} = '0;
  task automatic send(input logic [2:0] c, s, input logic p, input logic [2:0] i, input logic [7:0] d,
                      input logic sr, vc);
    @(negedge clk);
    {cmd_valid, cmd_code, cmd_sector, cmd_from_programmer, cfg_index} <= {1'b1, c, s[1:0], p, i};
    cfg_data <= d & (i < 4 ? 8'h07 : i == 4 ? 8'h1f : 8'h01);
    {stat_read, viol_clear} <= {sr, vc};
    @(negedge clk);
    {cmd_valid, stat_read, viol_clear} <= '0;
    // released code and data lines do not keep the last value
    {cmd_code, cfg_data} <= ~{c, d};
  endtask : send
  task automatic look(input logic [2:0] i);
    @(negedge clk);
    cfg_index <= i;
    @(negedge clk);
  endtask : look
endmodule : fssb_source
`default_nettype wire
